// ### design/pmr_pkg.sv
// package: offsets, field positions, reset values and carrier types of the phy register view
package pmr_pkg;

    // ********************************
    // bus geometry
    // ********************************
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 16;

    // ********************************
    // register offsets within a bank, and bank bases
    // ********************************
    localparam logic [7:0]  OFF_P2_CONTROL = 8'h00;
    localparam logic [7:0]  OFF_IDENT_LOW  = 8'h04;
    localparam logic [7:0]  OFF_IDENT_HIGH = 8'h06;
    localparam logic [7:0]  OFF_ADVERTISE  = 8'h08;
    localparam logic [7:0]  OFF_PARTNER    = 8'h0A;
    localparam logic [7:0]  BANK_P1_BASE   = 8'h00;
    localparam logic [7:0]  BANK_P2_BASE   = 8'h10;

    // ********************************
    // advertisement and partner ability fields
    // ********************************
    localparam int          ABL_PAUSE_BIT  = 10;
    localparam int          ABL_RSVD9_BIT  = 9;
    localparam int          ABL_CAP_HI     = 8;
    localparam int          ABL_CAP_LO     = 5;
    localparam int          ABL_SEL_HI     = 4;
    localparam int          ABL_SEL_LO     = 0;
    localparam logic [4:0]  SELECTOR_VAL   = 5'h01;
    localparam logic        ADV_PAUSE_RST  = 1'b1;
    localparam logic [3:0]  ADV_CAP_RST    = 4'hF;
    localparam logic        ADV_RSVD9_RST  = 1'b0;

    // ********************************
    // port 2 basic control fields
    // ********************************
    localparam int          P2_LOOP_BIT    = 14;
    localparam int          P2_F100_BIT    = 13;
    localparam int          P2_ANEN_BIT    = 12;
    localparam int          P2_PDN_BIT     = 11;
    localparam int          P2_RSTAN_BIT   = 9;
    localparam int          P2_FFD_BIT     = 8;
    localparam int          P2_XALG_BIT    = 5;
    localparam int          P2_FMDIX_BIT   = 4;
    localparam int          P2_DMDIX_BIT   = 3;
    localparam int          P2_RSVD2_BIT   = 2;
    localparam int          P2_DTX_BIT     = 1;
    localparam int          P2_DLED_BIT    = 0;
    localparam logic [15:0] P2_CTL_RST     = 16'h1020;

    // ********************************
    // carrier types
    // ********************************
    typedef struct packed {
        logic       pause;
        logic [3:0] cap;     // 100 full, 100 half, 10 full, 10 half
    } pmr_ability_s;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic failed;
    } pmr_an_result_s;

    typedef struct packed {
        logic far_loopback;
        logic force_100;
        logic an_enable;
        logic power_down;
        logic force_full;
        logic crossover_algorithm_select;
        logic force_mdix;
        logic disable_mdix;
        logic reserved_2;
        logic disable_tx;
        logic disable_led;
    } pmr_p2ctl_s;

    typedef enum logic [0:0] {
        RST_IDLE   = 1'b0,
        RST_LAUNCH = 1'b1
    } pmr_restart_e;

    // address hit on one register of one bank
    function automatic logic pmr_hit(input logic [7:0] addr,
                                     input logic [7:0] base,
                                     input logic [7:0] off);
        pmr_hit = (addr == (base | off));
    endfunction : pmr_hit

endpackage : pmr_pkg

// ### design/pmr_register_view.sv
// module: mii-style register view for port 1 identity and negotiation, port 2 control
// What this block does
// RULE_01 - port 1 low identifier reads fixed; writes ignored
// RULE_02 - port 1 high identifier reads fixed; writes ignored
// RULE_03 - advertise pause bit, default one, shared storage
// RULE_04 - advertise four speed/duplex bits, default one
// RULE_05 - advertise unused bits zero; selector reads one; bit 9 is stored here and reads back as written
// RULE_06 - partner pause bit mirrors status, read-only
// RULE_07 - partner speed/duplex bits mirror status, read-only
// RULE_08 - partner unused bits zero; selector one; read-only
// RULE_09 - port 2 bit 14 loops port 1 traffic
// RULE_10 - port 2 autoneg enable, speed, duplex controls
// RULE_11 - writing restart bit restarts port 2 autoneg
// RULE_12 - bit 5 picks crossover detection algorithm
// RULE_13 - bits 3/4 disable auto crossover, force crossed
// RULE_14 - bit 1 disables the port 2 transmitter
// RULE_15 - forced speed/duplex only when autoneg off/failed; forced speed here applies only with autoneg off
// RULE_16 - bit 11 powers down, bit 0 kills LEDs
// RULE_17 - unsupported control bits read zero; bit 2 inert
// RULE_18 - restart bit clears itself once launched
//
// Chosen here: the strobed register port.
module pmr_register_view
    import pmr_pkg::*;
#(
    parameter logic [15:0] IDENT_LOW  = 16'hA5C3,   // arbitrary value
    parameter logic [15:0] IDENT_HIGH = 16'h005A    // arbitrary value
)
(
    input  wire logic               core_clk_in,
    input  wire logic               rst_in,
    input  wire logic [ADDR_W-1:0]  reg_addr_in,
    input  wire logic [DATA_W-1:0]  reg_wdata_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output logic      [DATA_W-1:0]  reg_rdata_out,
    input  wire pmr_ability_s       partner_ability_in,
    input  wire pmr_an_result_s     p2_an_result_in,
    input  wire logic               p2_an_restart_ack_in,
    output pmr_ability_s            p1_advertise_out,
    output pmr_p2ctl_s              p2_ctl_out,
    output logic                    p2_an_restart_out,
    output logic                    p2_speed_100_out,
    output logic                    p2_full_duplex_out
);

    // ********************************
    // storage
    // ********************************
    pmr_ability_s       adv;
    pmr_ability_s       next_adv;
    logic               adv_rsvd9;
    logic               next_adv_rsvd9;
    pmr_p2ctl_s         p2ctl;
    pmr_p2ctl_s         next_p2ctl;
    logic [DATA_W-1:0]  rdata;
    logic [DATA_W-1:0]  next_rdata;
    logic               speed_100;
    logic               next_speed_100;
    logic               full_duplex;
    logic               next_full_duplex;
    logic               restart_pending;
    logic               restart_start;

    // decoded write strobes
    logic               wr_adv;
    logic               wr_p2ctl;

    // ********************************
    // address decode
    // ********************************
    // identifier and partner registers have no write decode at all, so writes vanish
    always_comb begin
        wr_adv   = 1'b0;
        wr_p2ctl = 1'b0;
        if (reg_wr_in && pmr_hit(reg_addr_in, BANK_P1_BASE, OFF_ADVERTISE)) begin
            wr_adv = 1'b1;
        end else if (reg_wr_in && pmr_hit(reg_addr_in, BANK_P2_BASE, OFF_P2_CONTROL)) begin
            wr_p2ctl = 1'b1;
        end
    end

    // ********************************
    // port 1 advertisement
    // ********************************
    // the same flops drive the negotiation engine, so there is one copy only
    always_comb begin
        next_adv       = adv;
        next_adv_rsvd9 = adv_rsvd9;
        if (wr_adv) begin
            next_adv.pause = reg_wdata_in[ABL_PAUSE_BIT];                 // RULE_03
            next_adv.cap   = reg_wdata_in[ABL_CAP_HI:ABL_CAP_LO];         // RULE_04
            next_adv_rsvd9 = reg_wdata_in[ABL_RSVD9_BIT];                 // RULE_05
        end
    end

    // advertisement register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            adv.pause <= ADV_PAUSE_RST;                                   // RULE_03
            adv.cap   <= ADV_CAP_RST;                                     // RULE_04
            adv_rsvd9 <= ADV_RSVD9_RST;
        end else begin
            adv       <= next_adv;
            adv_rsvd9 <= next_adv_rsvd9;
        end
    end

    assign p1_advertise_out = adv;

    // ********************************
    // port 2 basic control
    // ********************************
    // restart is not stored here: it lives in the launcher and reads back from there
    always_comb begin
        next_p2ctl = p2ctl;
        if (wr_p2ctl) begin
            next_p2ctl.far_loopback = reg_wdata_in[P2_LOOP_BIT];          // RULE_09
            next_p2ctl.force_100    = reg_wdata_in[P2_F100_BIT];          // RULE_10
            next_p2ctl.an_enable    = reg_wdata_in[P2_ANEN_BIT];          // RULE_10
            next_p2ctl.force_full   = reg_wdata_in[P2_FFD_BIT];           // RULE_10
            next_p2ctl.power_down   = reg_wdata_in[P2_PDN_BIT];           // RULE_16
            next_p2ctl.crossover_algorithm_select = reg_wdata_in[P2_XALG_BIT]; // RULE_12
            next_p2ctl.force_mdix   = reg_wdata_in[P2_FMDIX_BIT];         // RULE_13
            next_p2ctl.disable_mdix = reg_wdata_in[P2_DMDIX_BIT];         // RULE_13
            next_p2ctl.reserved_2   = reg_wdata_in[P2_RSVD2_BIT];         // RULE_17
            next_p2ctl.disable_tx   = reg_wdata_in[P2_DTX_BIT];           // RULE_14
            next_p2ctl.disable_led  = reg_wdata_in[P2_DLED_BIT];          // RULE_16
        end
    end

    // control register, reset fields taken from the packed reset word
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            p2ctl.far_loopback <= P2_CTL_RST[P2_LOOP_BIT];
            p2ctl.force_100    <= P2_CTL_RST[P2_F100_BIT];
            p2ctl.an_enable    <= P2_CTL_RST[P2_ANEN_BIT];
            p2ctl.power_down   <= P2_CTL_RST[P2_PDN_BIT];
            p2ctl.force_full   <= P2_CTL_RST[P2_FFD_BIT];
            p2ctl.crossover_algorithm_select <= P2_CTL_RST[P2_XALG_BIT];
            p2ctl.force_mdix   <= P2_CTL_RST[P2_FMDIX_BIT];
            p2ctl.disable_mdix <= P2_CTL_RST[P2_DMDIX_BIT];
            p2ctl.reserved_2   <= P2_CTL_RST[P2_RSVD2_BIT];
            p2ctl.disable_tx   <= P2_CTL_RST[P2_DTX_BIT];
            p2ctl.disable_led  <= P2_CTL_RST[P2_DLED_BIT];
        end else begin
            p2ctl <= next_p2ctl;
        end
    end

    assign p2_ctl_out = p2ctl;

    // ********************************
    // restart of port 2 negotiation
    // ********************************
    // writing zero has no effect; only a one launches a restart
    assign restart_start = wr_p2ctl && reg_wdata_in[P2_RSTAN_BIT];  // RULE_11

    pmr_restart_launcher u_restart (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .start_in    (restart_start),
        .ack_in      (p2_an_restart_ack_in),
        .pending_out (restart_pending)
    );

    assign p2_an_restart_out = restart_pending;

    // ********************************
    // effective port 2 speed and duplex
    // ********************************
    // forced speed only without negotiation; forced duplex also after a failed negotiation
    always_comb begin
        next_speed_100   = p2ctl.an_enable ? p2_an_result_in.speed_100
                                           : p2ctl.force_100;           // RULE_15
        next_full_duplex = (!p2ctl.an_enable || p2_an_result_in.failed)
                           ? p2ctl.force_full
                           : p2_an_result_in.full_duplex;               // RULE_15
    end

    // resolved mode register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            speed_100   <= 1'b0;
            full_duplex <= 1'b0;
        end else begin
            speed_100   <= next_speed_100;
            full_duplex <= next_full_duplex;
        end
    end

    assign p2_speed_100_out   = speed_100;
    assign p2_full_duplex_out = full_duplex;

    // ********************************
    // read path
    // ********************************
    // data stand for exactly the cycle after the strobe, zero otherwise and when unmapped
    always_comb begin
        next_rdata = '0;
        if (!reg_rd_in) begin
            next_rdata = '0;
        end else if (pmr_hit(reg_addr_in, BANK_P1_BASE, OFF_IDENT_LOW)) begin
            next_rdata = IDENT_LOW;                                       // RULE_01
        end else if (pmr_hit(reg_addr_in, BANK_P1_BASE, OFF_IDENT_HIGH)) begin
            next_rdata = IDENT_HIGH;                                      // RULE_02
        end else if (pmr_hit(reg_addr_in, BANK_P1_BASE, OFF_ADVERTISE)) begin
            next_rdata[ABL_PAUSE_BIT]          = adv.pause;               // RULE_03
            next_rdata[ABL_RSVD9_BIT]          = adv_rsvd9;
            next_rdata[ABL_CAP_HI:ABL_CAP_LO]  = adv.cap;                 // RULE_04
            next_rdata[ABL_SEL_HI:ABL_SEL_LO]  = SELECTOR_VAL;            // RULE_05
        end else if (pmr_hit(reg_addr_in, BANK_P1_BASE, OFF_PARTNER)) begin
            next_rdata[ABL_PAUSE_BIT]          = partner_ability_in.pause; // RULE_06
            next_rdata[ABL_CAP_HI:ABL_CAP_LO]  = partner_ability_in.cap;   // RULE_07
            next_rdata[ABL_SEL_HI:ABL_SEL_LO]  = SELECTOR_VAL;            // RULE_08
        end else if (pmr_hit(reg_addr_in, BANK_P2_BASE, OFF_P2_CONTROL)) begin
            next_rdata[P2_LOOP_BIT]  = p2ctl.far_loopback;
            next_rdata[P2_F100_BIT]  = p2ctl.force_100;
            next_rdata[P2_ANEN_BIT]  = p2ctl.an_enable;
            next_rdata[P2_PDN_BIT]   = p2ctl.power_down;
            next_rdata[P2_RSTAN_BIT] = restart_pending;                   // RULE_18
            next_rdata[P2_FFD_BIT]   = p2ctl.force_full;
            next_rdata[P2_XALG_BIT]  = p2ctl.crossover_algorithm_select;
            next_rdata[P2_FMDIX_BIT] = p2ctl.force_mdix;
            next_rdata[P2_DMDIX_BIT] = p2ctl.disable_mdix;
            next_rdata[P2_RSVD2_BIT] = p2ctl.reserved_2;                  // RULE_17
            next_rdata[P2_DTX_BIT]   = p2ctl.disable_tx;
            next_rdata[P2_DLED_BIT]  = p2ctl.disable_led;
        end
    end

    // read data register
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_out = rdata;

endmodule : pmr_register_view

// ### design/pmr_restart_launcher.sv
// module: self-clearing auto-negotiation restart request for port 2
module pmr_restart_launcher
    import pmr_pkg::*;
(
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic start_in,
    input  wire logic ack_in,
    output logic      pending_out
);

    pmr_restart_e state;
    pmr_restart_e next_state;

    // ********************************
    // next state
    // ********************************
    // a fresh start in the ack cycle keeps the request alive, so no restart is lost
    always_comb begin
        next_state = state;
        case (state)
            RST_IDLE: begin
                if (start_in) begin
                    next_state = RST_LAUNCH;             // RULE_11
                end
            end
            RST_LAUNCH: begin
                if (ack_in && !start_in) begin
                    next_state = RST_IDLE;               // RULE_18
                end
            end
            default: begin
                next_state = RST_IDLE;
            end
        endcase
    end

    // state register only
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= RST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign pending_out = (state == RST_LAUNCH);

endmodule : pmr_restart_launcher

// ### verification/pmr_link_partner_model.sv
// partner: remote link end that answers a restart after a set delay
module pmr_link_partner_model
    import pmr_pkg::*;
(
    input  wire logic           core_clk_in,
    input  wire logic           rst_in,
    input  wire logic           restart_in,
    input  wire pmr_ability_s   ability_cfg_in,
    input  wire pmr_an_result_s result_cfg_in,
    input  wire logic [3:0]     delay_in,
    output pmr_ability_s        ability_out,
    output pmr_an_result_s      result_out,
    output logic                ack_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;
    // new abilities appear only when a negotiation completes, as on a real link
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ability_out <= '0;
            result_out  <= '0;
            ack_out     <= 1'b0;
            wait_cnt    <= 4'h0;
        end else begin
            ack_out <= 1'b0;
            if (restart_in && !ack_out) begin
                wait_cnt <= (wait_cnt >= delay_in) ? 4'h0 : wait_cnt + 4'h1;
                if (wait_cnt >= delay_in) begin
                    ack_out     <= 1'b1;
                    ability_out <= ability_cfg_in;
                    result_out  <= result_cfg_in;
                end
            end
        end
    end
endmodule : pmr_link_partner_model

// ### verification/pmr_register_view_monitor.sv
// checker: bus, control and restart relations of the phy register view
module pmr_register_view_monitor
    import pmr_pkg::*;
#(
    parameter logic [15:0] IDENT_LOW  = 16'hA5C3,
    parameter logic [15:0] IDENT_HIGH = 16'h005A
)
(
    input wire logic              core_clk_in,
    input wire logic              rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire pmr_ability_s      partner_ability_in,
    input wire pmr_an_result_s    p2_an_result_in,
    input wire logic              p2_an_restart_ack_in,
    input wire pmr_ability_s      p1_advertise_out,
    input wire pmr_p2ctl_s        p2_ctl_out,
    input wire logic              p2_an_restart_out,
    input wire logic              p2_speed_100_out,
    input wire logic              p2_full_duplex_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_IL = BANK_P1_BASE | OFF_IDENT_LOW;
    localparam logic [7:0] A_IH = BANK_P1_BASE | OFF_IDENT_HIGH;
    localparam logic [7:0] A_AD = BANK_P1_BASE | OFF_ADVERTISE;
    localparam logic [7:0] A_PA = BANK_P1_BASE | OFF_PARTNER;
    localparam logic [7:0] A_CT = BANK_P2_BASE | OFF_P2_CONTROL;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // ********************************
    // helpers: last-cycle copies, since a field of a $past result cannot be selected
    // ********************************
    logic [15:0]    lw;
    pmr_ability_s   lpa;
    pmr_p2ctl_s     lctl;
    pmr_an_result_s lan;
    logic           kick;
    assign kick = reg_wr_in && reg_addr_in == A_CT && reg_wdata_in[P2_RSTAN_BIT];
    // no reset: they only ever mirror the previous edge
    always_ff @(posedge core_clk_in) begin
        lw   <= reg_wdata_in;
        lpa  <= partner_ability_in;
        lctl <= p2_ctl_out;
        lan  <= p2_an_result_in;
    end
    sequence rd_s(a); reg_rd_in && reg_addr_in == a; endsequence
    sequence wr_s(a); reg_wr_in && reg_addr_in == a; endsequence
    sequence kick_s; kick; endsequence
    sequence waiting_s; p2_an_restart_out && !p2_an_restart_ack_in; endsequence
    ident_low_a: assert property (rd_s(A_IL) |=> reg_rdata_out == IDENT_LOW)
        else $error("ident low read wrong");
    ident_high_a: assert property (rd_s(A_IH) |=> reg_rdata_out == IDENT_HIGH)
        else $error("ident high read wrong");
    adv_read_a: assert property (rd_s(A_AD) |=> reg_rdata_out[15:11] == 5'h00
        && reg_rdata_out[4:0] == SELECTOR_VAL && reg_rdata_out[10] == p1_advertise_out.pause
        && reg_rdata_out[8:5] == p1_advertise_out.cap) else $error("advertise read wrong");
    adv_write_a: assert property (wr_s(A_AD) |=> p1_advertise_out == {lw[10], lw[8:5]})
        else $error("advertise write lost");
    partner_read_a: assert property (rd_s(A_PA) |=>
        reg_rdata_out == {5'h00, lpa.pause, 1'b0, lpa.cap, SELECTOR_VAL})
        else $error("partner read wrong");
    ctl_write_a: assert property (wr_s(A_CT) |=> p2_ctl_out == {lw[14:11], lw[8], lw[5:0]})
        else $error("control write lost");
    ctl_read_a: assert property (rd_s(A_CT) |=> reg_rdata_out[15] == 1'b0
        && reg_rdata_out[10] == 1'b0 && reg_rdata_out[7:6] == 2'h0
        && reg_rdata_out[12] == lctl.an_enable) else $error("control read wrong");
    restart_set_a: assert property (kick_s |=> p2_an_restart_out)
        else $error("restart not raised");
    restart_hold_a: assert property (waiting_s |=> p2_an_restart_out)
        else $error("restart dropped before ack");
    restart_clear_a: assert property (p2_an_restart_out && p2_an_restart_ack_in && !kick
        |=> !p2_an_restart_out) else $error("restart not cleared");
    speed_res_a: assert property (!$past(rst_in) |-> p2_speed_100_out ==
        (lctl.an_enable ? lan.speed_100 : lctl.force_100)) else $error("speed wrong");
    duplex_res_a: assert property (!$past(rst_in) |-> p2_full_duplex_out ==
        ((!lctl.an_enable || lan.failed) ? lctl.force_full : lan.full_duplex))
        else $error("duplex wrong");
endmodule : pmr_register_view_monitor

bind pmr_register_view pmr_register_view_monitor #(.IDENT_LOW(IDENT_LOW), .IDENT_HIGH(IDENT_HIGH))
    u_mon (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .partner_ability_in(partner_ability_in),
    .p2_an_result_in(p2_an_result_in), .p2_an_restart_ack_in(p2_an_restart_ack_in),
    .p1_advertise_out(p1_advertise_out), .p2_ctl_out(p2_ctl_out),
    .p2_an_restart_out(p2_an_restart_out), .p2_speed_100_out(p2_speed_100_out),
    .p2_full_duplex_out(p2_full_duplex_out));

// ### verification/pmr_register_view_test.sv
// testbench: register map, control, restart and resolution scenarios
module pmr_register_view_test
    import pmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID_LO = 16'h3C5A;   // arbitrary value
    localparam logic [15:0] ID_HI = 16'h00B7;   // arbitrary value
    localparam logic [7:0]  A_IL  = BANK_P1_BASE | OFF_IDENT_LOW;
    localparam logic [7:0]  A_IH  = BANK_P1_BASE | OFF_IDENT_HIGH;
    localparam logic [7:0]  A_AD  = BANK_P1_BASE | OFF_ADVERTISE;
    localparam logic [7:0]  A_PA  = BANK_P1_BASE | OFF_PARTNER;
    localparam logic [7:0]  A_CT  = BANK_P2_BASE | OFF_P2_CONTROL;
    logic clk, rst, wr, rd, ack, rs, spd, dup;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic [3:0] dly;
    pmr_ability_s pa, cfg_pa, adv;
    pmr_an_result_s an, cfg_an;
    pmr_p2ctl_s ctl;
    int err_total, num_checks;
    pmr_register_view #(.IDENT_LOW(ID_LO), .IDENT_HIGH(ID_HI)) dut (.core_clk_in(clk),
        .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .partner_ability_in(pa), .p2_an_result_in(an),
        .p2_an_restart_ack_in(ack), .p1_advertise_out(adv), .p2_ctl_out(ctl),
        .p2_an_restart_out(rs), .p2_speed_100_out(spd), .p2_full_duplex_out(dup));
    pmr_link_partner_model u_lp (.core_clk_in(clk), .rst_in(rst), .restart_in(rs),
        .ability_cfg_in(cfg_pa), .result_cfg_in(cfg_an), .delay_in(dly),
        .ability_out(pa), .result_out(an), .ack_out(ack));
    always #50 clk = ~clk;
    // ********************************
    // bus tasks and comparison
    // ********************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    // read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask : rd_chk
    task automatic wait_clear();
        for (int i = 0; i < 40 && rs !== 1'b0; i++) @(negedge clk);
        if (rs !== 1'b0) begin
            err_total++;
            $display("MISMATCH t=%0t restart never completed", $time);
            summarize();
        end
        @(negedge clk);
    endtask : wait_clear
    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(A_AD, 16'h05E1);
        rd_chk(A_CT, 16'h1020);
        rd_chk(A_PA, 16'h0001);
        check({adv, ctl}, {5'h1F, 11'h120});
        check(16'(rs), 16'h0000);
    endtask : t_reset
    task automatic t_readonly();
        bus_wr(A_IL, 16'hFFFF);
        bus_wr(A_IH, 16'hFFFF);
        bus_wr(A_PA, 16'hFFFF);
        bus_wr(8'h02, 16'hFFFF);
        rd_chk(A_IL, ID_LO);
        rd_chk(A_IH, ID_HI);
        rd_chk(A_PA, 16'h0001);
        rd_chk(8'h02, 16'h0000);
    endtask : t_readonly
    task automatic t_advertise();
        bus_wr(A_AD, 16'hFFFF);
        rd_chk(A_AD, 16'h07E1);
        check(16'(adv), 16'h001F);
        bus_wr(A_AD, 16'h0420);
        rd_chk(A_AD, 16'h0421);
        check(16'(adv), 16'h0011);
    endtask : t_advertise
    task automatic t_control();
        dly <= 4'h6;
        bus_wr(A_CT, 16'hFFFF);
        rd_chk(A_CT, 16'h7B3F);
        check(16'(ctl), 16'h07FF);
        wait_clear();
        rd_chk(A_CT, 16'h793F);
        bus_wr(A_CT, 16'h0000);
        rd_chk(A_CT, 16'h0000);
        check(16'({ctl, spd, dup}), 16'h0000);
        bus_wr(A_CT, 16'h2100);
        rd_chk(A_CT, 16'h2100);
        check(16'({spd, dup}), 16'h0003);
    endtask : t_control
    task automatic t_negotiate();
        cfg_pa <= 5'h15;
        cfg_an <= 3'b110;
        dly <= 4'h0;
        bus_wr(A_CT, 16'h1200);
        @(negedge clk);
        check(16'(rs), 16'h0001);
        wait_clear();
        rd_chk(A_PA, 16'h04A1);
        check(16'({spd, dup}), 16'h0003);
        cfg_an <= 3'b011;
        dly <= 4'h3;
        bus_wr(A_CT, 16'h1200);
        // the request only shows after the write edge has settled
        @(negedge clk);
        check(16'(rs), 16'h0001);
        wait_clear();
        check(16'({spd, dup}), 16'h0000);
    endtask : t_negotiate
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {wr, rd, addr, wdata, cfg_pa, cfg_an} = '0;
        dly = 4'h0;
        err_total = 0;
        num_checks = 0;
        t_reset();
        t_readonly();
        t_advertise();
        t_control();
        t_negotiate();
        t_reset();
        summarize();
    end
endmodule : pmr_register_view_test
